/* File: zrs_regs.svh */
`ifndef ZRS_REGS_SVH
`define ZRS_REGS_SVH

// register byte offsets
`define ZRS_CTRL_ADDR 12'h000
`define ZRS_STATUS_ADDR 12'h004
`define ZRS_ZR_SPEED_ADDR 12'h008
`define ZRS_CREEP_SPEED_ADDR 12'h00C
`define ZRS_MAX_SPEED_ADDR 12'h010
`define ZRS_CLR_DEV_ADDR 12'h014
`define ZRS_POSITION_ADDR 12'h018
`define ZRS_SCAN_TIME_ADDR 12'h01C

// control field positions
`define ZRS_CTRL_ACTIVATE 0
`define ZRS_CTRL_CLR_OUT_EN 1
`define ZRS_CTRL_CLR_DEV_SEL_EN 2
`define ZRS_CTRL_FAST_INPUT 3
`define ZRS_CTRL_CH_LSB 4

// status field positions
`define ZRS_STAT_BUSY 0
`define ZRS_STAT_COMPLETE 1
`define ZRS_STAT_ABNORMAL 2
`define ZRS_STAT_CLEAR 3
`define ZRS_STAT_REFUSED 4

// reset values
`define ZRS_MAX_SPEED_RST 32'h000186A0
`define ZRS_SCAN_TIME_RST 16'h000A

// timing: clock 200 MHz
`define ZRS_CLK_HZ 200000000
`define ZRS_CLEAR_HOLD_MS 20
`define ZRS_CLEAR_HOLD_CYC (`ZRS_CLEAR_HOLD_MS * (`ZRS_CLK_HZ / 1000))
`define ZRS_MS_CYC (`ZRS_CLK_HZ / 1000)
`define ZRS_DECEL_STEP_HZ 32'h00000064

`endif

/* File: zrs_pkg.sv */
`default_nettype none
package zrs_pkg;
  typedef enum logic [2:0] {
    ZRS_IDLE = 3'b000,
    ZRS_FAST = 3'b001,
    ZRS_CREEP = 3'b011,
    ZRS_CLEAR = 3'b010,
    ZRS_DONE = 3'b110,
    ZRS_DECEL = 3'b100
  } zrs_state_type;

  typedef enum logic [1:0] {
    ZRS_END_OK = 2'h0,
    ZRS_END_ABORT = 2'h1,
    ZRS_END_LIMIT = 2'h2
  } zrs_end_type;
endpackage : zrs_pkg
`default_nettype wire

/* File: zrs_pulse_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "zrs_regs.svh"
module zrs_pulse_gen (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic run,
  input wire logic [31:0] rate_hz,
  output logic step
);
  typedef struct packed {
    logic [31:0] acc;
    logic step;
  } zrs_pg_type;
  zrs_pg_type s_q;
  zrs_pg_type s_d;
  logic [32:0] sum;

  // phase accumulator: one step each time acc passes the clock rate
  always_comb
  begin
    s_d = s_q;
    sum = {1'b0, s_q.acc} + {1'b0, rate_hz};
    s_d.step = 1'b0;
    if (!run)
    begin
      s_d.acc = 32'h00000000;
    end
    else if (sum >= 33'(`ZRS_CLK_HZ))
    begin
      s_d.acc = 32'(sum - 33'(`ZRS_CLK_HZ));
      s_d.step = 1'b1;
    end
    else
    begin
      s_d.acc = sum[31:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign step = s_q.step;
endmodule : zrs_pulse_gen
`default_nettype wire

/* File: zrs_sequencer.sv */
// What this block does
// - on start, pulses run at zero-return speed until the near-point input rises
// - near-point rising edge decelerates pulse rate down to creep speed
// - near-point falling edge stops pulses at once, no ramp
// - clear output asserted within 1 ms of falling edge, held 20 ms plus scan
// - slow near-point input allows 1 ms plus one scan time latency
// - after origin stop the 32-bit current position resets to zero
// - after stop and clear, complete flag set and run ends
// - default clear output per channel: channels 0..3 use outputs 4..7
// - with device select enabled, clear drives the output number from register
// - activation dropping mid-run decelerates and stops, no complete flag
// - while busy, a fresh start through the activate bit is refused
// - forward or reverse limit decelerates, stops, then sets abnormal-end flag
// - limit opposite to travel also stops with abnormal-end flag
// - no zero-phase marker; origin is near-point falling edge only
// - a fast near-point input is reserved from other input functions
// - homing runs reverse, decrementing the current position register
// - zero-return speed above maximum runs at maximum speed
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "zrs_regs.svh"
module zrs_sequencer (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic near_point_input,
  input wire logic fwd_limit_in,
  input wire logic rev_limit_in,
  output logic pulse_out,
  output logic [7:0] clear_out,
  output logic near_point_reserved,
  output logic busy,
  output logic exec_complete_flag,
  output logic abnormal_end_flag
);
  typedef struct packed {
    zrs_pkg::zrs_state_type state;
    zrs_pkg::zrs_end_type end_kind;
    logic [2:0] np_sync;
    logic [1:0] fl_sync;
    logic [1:0] rl_sync;
    logic activate;
    logic clr_out_en;
    logic clr_dev_sel_en;
    logic fast_input;
    logic [1:0] channel;
    logic [31:0] zr_speed;
    logic [31:0] creep_speed;
    logic [31:0] max_speed;
    logic [2:0] clr_dev;
    logic [31:0] position;
    logic [15:0] scan_ms;
    logic [31:0] rate;
    logic [31:0] timer;
    logic [31:0] latency;
    logic clear_on;
    logic [2:0] clear_sel;
    logic complete;
    logic abnormal;
    logic refused;
    logic [31:0] rdata;
  } zrs_seq_type;
  zrs_seq_type s_q;
  zrs_seq_type s_d;

  logic step;
  logic running;
  logic np_rise;
  logic np_fall;
  logic limit_hit;
  logic wr_en;
  logic rd_en;
  logic [31:0] zr_eff;

  // clear output number for a channel with the default mapping
  function automatic logic [2:0] zrs_default_clear(input logic [1:0] ch);
    zrs_default_clear = {1'b1, ch};
  endfunction : zrs_default_clear

  // decode of a valid register address, shared by read and write
  function automatic logic zrs_addr_ok(input logic [11:0] a);
    zrs_addr_ok = (a[1:0] == 2'h0) && (a <= `ZRS_SCAN_TIME_ADDR);
  endfunction : zrs_addr_ok

  zrs_pulse_gen u_pulse (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(running),
    .rate_hz(s_q.rate),
    .step(step)
  );

  // a step already in flight when the run state ends is swallowed here
  assign running = (s_q.state == zrs_pkg::ZRS_FAST) || (s_q.state == zrs_pkg::ZRS_CREEP)
    || (s_q.state == zrs_pkg::ZRS_DECEL);
  // edges only from the second and third stages, never the first
  assign np_rise = s_q.np_sync[1] && !s_q.np_sync[2];
  assign np_fall = !s_q.np_sync[1] && s_q.np_sync[2];
  // either limit stops, whichever side it lies on
  assign limit_hit = s_q.fl_sync[1] || s_q.rl_sync[1];
  assign zr_eff = (s_q.zr_speed > s_q.max_speed) ? s_q.max_speed : s_q.zr_speed;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // next-state logic for registers, sequencer and clear timing
  always_comb
  begin
    s_d = s_q;
    s_d.np_sync = {s_q.np_sync[1:0], near_point_input};
    s_d.fl_sync = {s_q.fl_sync[0], fwd_limit_in};
    s_d.rl_sync = {s_q.rl_sync[0], rev_limit_in};
    s_d.refused = 1'b0;

    // register writes
    if (wr_en && zrs_addr_ok(paddr))
    begin
      case (paddr)
        `ZRS_CTRL_ADDR:
        begin
          s_d.activate = pwdata[`ZRS_CTRL_ACTIVATE];
          s_d.clr_out_en = pwdata[`ZRS_CTRL_CLR_OUT_EN];
          s_d.clr_dev_sel_en = pwdata[`ZRS_CTRL_CLR_DEV_SEL_EN];
          s_d.fast_input = pwdata[`ZRS_CTRL_FAST_INPUT];
          // channel is fixed while busy so the run cannot move outputs
          if (s_q.state == zrs_pkg::ZRS_IDLE)
            s_d.channel = pwdata[`ZRS_CTRL_CH_LSB +: 2];
          // a fresh start while a run is live is refused
          if (pwdata[`ZRS_CTRL_ACTIVATE] && !s_q.activate && s_q.state != zrs_pkg::ZRS_IDLE)
            s_d.refused = 1'b1;
        end
        `ZRS_ZR_SPEED_ADDR: s_d.zr_speed = pwdata;
        `ZRS_CREEP_SPEED_ADDR: s_d.creep_speed = pwdata;
        `ZRS_MAX_SPEED_ADDR: s_d.max_speed = pwdata;
        `ZRS_CLR_DEV_ADDR: s_d.clr_dev = pwdata[2:0];
        `ZRS_POSITION_ADDR:
        begin
          if (s_q.state == zrs_pkg::ZRS_IDLE)
            s_d.position = pwdata;
        end
        `ZRS_SCAN_TIME_ADDR: s_d.scan_ms = pwdata[15:0];
        default: s_d.rdata = s_q.rdata;
      endcase
    end

    // read data captured in setup so it stands through access
    if (rd_en)
    begin
      case (paddr)
        `ZRS_CTRL_ADDR: s_d.rdata = {26'h0, s_q.channel, s_q.fast_input, s_q.clr_dev_sel_en,
          s_q.clr_out_en, s_q.activate};
        `ZRS_STATUS_ADDR: s_d.rdata = {27'h0, s_q.refused, s_q.clear_on, s_q.abnormal,
          s_q.complete, (s_q.state != zrs_pkg::ZRS_IDLE)};
        `ZRS_ZR_SPEED_ADDR: s_d.rdata = s_q.zr_speed;
        `ZRS_CREEP_SPEED_ADDR: s_d.rdata = s_q.creep_speed;
        `ZRS_MAX_SPEED_ADDR: s_d.rdata = s_q.max_speed;
        `ZRS_CLR_DEV_ADDR: s_d.rdata = {29'h0, s_q.clr_dev};
        `ZRS_POSITION_ADDR: s_d.rdata = s_q.position;
        `ZRS_SCAN_TIME_ADDR: s_d.rdata = {16'h0, s_q.scan_ms};
        default: s_d.rdata = 32'h00000000;
      endcase
    end

    // each step moves the axis one count in reverse
    if (step && running)
      s_d.position = s_q.position - 32'h00000001;

    case (s_q.state)
      zrs_pkg::ZRS_IDLE:
      begin
        // flags drop when the activation input is turned off
        if (!s_q.activate)
        begin
          s_d.complete = 1'b0;
          s_d.abnormal = 1'b0;
        end
        if (s_d.activate && !s_q.activate)
        begin
          s_d.complete = 1'b0;
          s_d.abnormal = 1'b0;
          s_d.rate = zr_eff;
          s_d.end_kind = zrs_pkg::ZRS_END_OK;
          s_d.state = zrs_pkg::ZRS_FAST;
        end
      end
      zrs_pkg::ZRS_FAST:
      begin
        if (!s_q.activate)
        begin
          s_d.end_kind = zrs_pkg::ZRS_END_ABORT;
          s_d.state = zrs_pkg::ZRS_DECEL;
        end
        else if (limit_hit)
        begin
          s_d.end_kind = zrs_pkg::ZRS_END_LIMIT;
          s_d.state = zrs_pkg::ZRS_DECEL;
        end
        else if (np_rise)
          s_d.state = zrs_pkg::ZRS_CREEP;
        else
          s_d.rate = zr_eff;
      end
      zrs_pkg::ZRS_CREEP:
      begin
        // ramp down toward creep one step per millisecond tick
        if (s_q.timer == 32'h0)
        begin
          s_d.timer = 32'(`ZRS_MS_CYC - 1);
          if (s_q.rate > s_q.creep_speed + `ZRS_DECEL_STEP_HZ)
            s_d.rate = s_q.rate - `ZRS_DECEL_STEP_HZ;
          else
            s_d.rate = s_q.creep_speed;
        end
        else
          s_d.timer = s_q.timer - 32'h1;
        if (!s_q.activate)
        begin
          s_d.end_kind = zrs_pkg::ZRS_END_ABORT;
          s_d.state = zrs_pkg::ZRS_DECEL;
        end
        else if (limit_hit)
        begin
          s_d.end_kind = zrs_pkg::ZRS_END_LIMIT;
          s_d.state = zrs_pkg::ZRS_DECEL;
        end
        else if (np_fall)
        begin
          // origin is this edge alone; no marker input exists
          s_d.rate = 32'h0;
          s_d.position = 32'h00000000;
          s_d.clear_sel = s_q.clr_dev_sel_en ? s_q.clr_dev : zrs_default_clear(s_q.channel);
          s_d.clear_on = s_q.clr_out_en;
          // slow inputs wait one scan before the pulse; no clear wanted, no wait
          s_d.latency = (s_q.fast_input || !s_q.clr_out_en) ? 32'h0
            : 32'(s_q.scan_ms) * 32'(`ZRS_MS_CYC);
          s_d.timer = 32'(`ZRS_CLEAR_HOLD_CYC) + 32'(s_q.scan_ms) * 32'(`ZRS_MS_CYC);
          s_d.state = zrs_pkg::ZRS_CLEAR;
        end
      end
      zrs_pkg::ZRS_CLEAR:
      begin
        if (s_q.latency != 32'h0)
          s_d.latency = s_q.latency - 32'h1;
        else if (s_q.clear_on && s_q.timer != 32'h0)
          s_d.timer = s_q.timer - 32'h1;
        else
        begin
          s_d.clear_on = 1'b0;
          s_d.state = zrs_pkg::ZRS_DONE;
        end
      end
      zrs_pkg::ZRS_DONE:
      begin
        s_d.complete = 1'b1;
        s_d.state = zrs_pkg::ZRS_IDLE;
      end
      zrs_pkg::ZRS_DECEL:
      begin
        // short ramp down before stopping, no origin clear
        if (s_q.rate > `ZRS_DECEL_STEP_HZ)
          s_d.rate = s_q.rate - `ZRS_DECEL_STEP_HZ;
        else
        begin
          s_d.rate = 32'h0;
          s_d.abnormal = (s_q.end_kind == zrs_pkg::ZRS_END_LIMIT);
          s_d.state = zrs_pkg::ZRS_IDLE;
        end
      end
      default: s_d.state = zrs_pkg::ZRS_IDLE;
    endcase
  end

  // single register for all state
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.max_speed <= `ZRS_MAX_SPEED_RST;
      s_q.scan_ms <= `ZRS_SCAN_TIME_RST;
      s_q.state <= zrs_pkg::ZRS_IDLE;
    end
    else
      s_q <= s_d;
  end

  // clear line fans out to the chosen output number
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_clear
      assign clear_out[gi] = s_q.clear_on && (s_q.latency == 32'h0)
        && (s_q.clear_sel == 3'(gi));
    end
  endgenerate

  assign pulse_out = step && running;
  assign busy = (s_q.state != zrs_pkg::ZRS_IDLE);
  assign near_point_reserved = s_q.fast_input;
  assign exec_complete_flag = s_q.complete;
  assign abnormal_end_flag = s_q.abnormal;
  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !zrs_addr_ok(paddr);

  // no pulse may leave in the four cycles after the origin edge was seen
  a_stop_abrupt: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.state == zrs_pkg::ZRS_CREEP && s_q.activate && !limit_hit && np_fall) |=> !pulse_out [*4])
    else $error("pulse after origin edge");
  a_pos_clear: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.state == zrs_pkg::ZRS_CREEP && s_d.state == zrs_pkg::ZRS_CLEAR) |=> (s_q.position == 32'h0))
    else $error("position not cleared at origin");
  a_complete_set: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.state == zrs_pkg::ZRS_DONE) |=> exec_complete_flag && !busy)
    else $error("complete flag missing");
  a_abort_flag: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.state == zrs_pkg::ZRS_DECEL && s_q.end_kind == zrs_pkg::ZRS_END_ABORT) |-> !exec_complete_flag)
    else $error("complete set on abort");
  a_limit_flag: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.state == zrs_pkg::ZRS_DECEL && s_d.state == zrs_pkg::ZRS_IDLE
      && s_q.end_kind == zrs_pkg::ZRS_END_LIMIT) |=> abnormal_end_flag)
    else $error("abnormal flag missing");
  a_speed_cap: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.state == zrs_pkg::ZRS_FAST) |-> (s_q.rate <= s_q.max_speed))
    else $error("rate above maximum");
  a_fast_clear: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.state == zrs_pkg::ZRS_CREEP && s_d.state == zrs_pkg::ZRS_CLEAR && s_q.clr_out_en && s_q.fast_input)
    |=> (clear_out != 8'h00))
    else $error("clear output late");
  a_default_map: assert property (@(posedge clk_sys) disable iff (reset)
    (clear_out != 8'h00 && !s_q.clr_dev_sel_en) |-> clear_out[{1'b1, s_q.channel}])
    else $error("clear on wrong output");
endmodule : zrs_sequencer
`default_nettype wire

/* File: zrs_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module zrs_motor_model (
  input wire logic clk_sys,
  input wire logic restart,
  input wire logic cam_en,
  input wire logic [15:0] rise_at,
  input wire logic [15:0] cam_len,
  input wire logic pulse_out,
  output logic near_point_input,
  output logic [31:0] pulse_count,
  output logic [15:0] late_count
);
  logic passed;

  // axis position in steps; the cam sits rise_at steps away, cam_len steps long
  always_ff @(posedge clk_sys)
  begin
    if (restart)
    begin
      pulse_count <= 32'h0;
      late_count <= 16'h0;
      passed <= 1'b0;
      near_point_input <= 1'b0; // axis parked on the approach side
    end
    else
    begin
      if (pulse_out)
        pulse_count <= pulse_count + 32'h1;
      if (cam_en && !passed && pulse_count == {16'h0, rise_at})
        near_point_input <= 1'b1;
      // cam long enough for creep to settle before its rear end
      if (near_point_input && pulse_count == {16'h0, rise_at + cam_len})
      begin
        near_point_input <= 1'b0;
        passed <= 1'b1;
      end
      // steps past the origin count as overshoot
      if (passed && pulse_out)
        late_count <= late_count + 16'h1;
    end
  end
endmodule : zrs_motor_model
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "zrs_regs.svh"
module tb;
  logic clk_sys, reset, psel, penable, pwrite, fwd_limit_in, rev_limit_in, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pulse_count, pos0, cnt0;
  logic pulse_out, near_point_reserved, busy, exec_complete_flag, abnormal_end_flag, near_point_input;
  logic [7:0] clear_out, exp_clr;
  logic restart, cam_en, saw_done;
  logic [15:0] rise_at, cam_len, late_count;
  logic [1:0] ch;
  logic [32:0] exp_q[$];
  int num_errors, n_compared, cyc, k;

  zrs_sequencer dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .near_point_input, .fwd_limit_in, .rev_limit_in, .pulse_out, .clear_out,
    .near_point_reserved, .busy, .exec_complete_flag, .abnormal_end_flag);
  zrs_motor_model motor (.clk_sys, .restart, .cam_en, .rise_at, .cam_len, .pulse_out,
    .near_point_input, .pulse_count, .late_count);

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] expv);
    n_compared++;
    if (seen !== expv)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask : check

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // one apb transfer; a read notes its expected {pslverr, prdata} first
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
      exp_q.push_back(e);
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_busy(input logic v, input int lim);
    k = 0;
    while (busy !== v && k < lim)
    begin
      @(posedge clk_sys);
      k++;
    end
    check(busy, v);
  endtask : wait_busy

  // control word written from zero so activate sees a clean rising edge
  task automatic start_run(input logic [31:0] ctl, input logic en, input logic [15:0] ra);
    restart <= 1'b1;
    cam_en <= en;
    rise_at <= ra;
    apb(1'b1, `ZRS_CTRL_ADDR, 32'h0, 33'h0);
    restart <= 1'b0;
    apb(1'b1, `ZRS_CTRL_ADDR, ctl, 33'h0);
    wait_busy(1'b1, 10);
  endtask : start_run

  task automatic do_reset();
    reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
  endtask : do_reset

  // read results are compared at the edge that completes the access
  always @(posedge clk_sys)
  begin
    if (restart)
      saw_done <= 1'b0;
    else if (exec_complete_flag === 1'b1)
      saw_done <= 1'b1;
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      check({pslverr, prdata}, exp_q.pop_front());
  end

  // hang guard, well above the few tens of thousands of cycles the run needs
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  initial
  begin
    {reset, restart} = 2'b11;
    {psel, penable, pwrite, fwd_limit_in, rev_limit_in, cam_en} = 6'h0;
    {paddr, pwdata, rise_at, cam_len} = '0;
    void'($urandom(46066));
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, `ZRS_MAX_SPEED_ADDR, 32'h0, {1'b0, `ZRS_MAX_SPEED_RST});
    apb(1'b0, `ZRS_SCAN_TIME_ADDR, 32'h0, {17'h0, `ZRS_SCAN_TIME_RST});
    apb(1'b1, `ZRS_STATUS_ADDR, 32'hFFFFFFFF, 33'h0);
    apb(1'b0, `ZRS_STATUS_ADDR, 32'h0, 33'h0);
    apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
    // requested speed twice the ceiling, so the ceiling must win
    apb(1'b1, `ZRS_MAX_SPEED_ADDR, 32'h0007A120, 33'h0);
    apb(1'b1, `ZRS_ZR_SPEED_ADDR, 32'h000F4240, 33'h0);
    apb(1'b1, `ZRS_CREEP_SPEED_ADDR, 32'h0007A120, 33'h0);
    apb(1'b1, `ZRS_SCAN_TIME_ADDR, 32'h00000001, 33'h0);
    // limit stops: forward then reverse, both while travelling reverse
    for (int i = 0; i < 2; i++)
    begin
      pos0 = $urandom;
      apb(1'b1, `ZRS_POSITION_ADDR, pos0, 33'h0);
      start_run(32'h1, 1'b0, 16'h0);
      cnt0 = pulse_count;
      repeat (8000) @(posedge clk_sys);
      check((pulse_count - cnt0) inside {[18:22]}, 1'b1);
      apb(1'b1, `ZRS_POSITION_ADDR, 32'h0, 33'h0);
      if (i == 0)
        fwd_limit_in <= 1'b1;
      else
        rev_limit_in <= 1'b1;
      wait_busy(1'b0, 20000);
      check({exec_complete_flag, abnormal_end_flag}, 2'b01);
      apb(1'b0, `ZRS_POSITION_ADDR, 32'h0, {1'b0, pos0 - pulse_count});
      apb(1'b0, `ZRS_STATUS_ADDR, 32'h0, 33'h4);
      fwd_limit_in <= 1'b0;
      rev_limit_in <= 1'b0;
      apb(1'b1, `ZRS_CTRL_ADDR, 32'h0, 33'h0);
    end
    // abort by dropping activate mid-run
    start_run(32'h1, 1'b0, 16'h0);
    repeat (2000) @(posedge clk_sys);
    apb(1'b1, `ZRS_CTRL_ADDR, 32'h0, 33'h0);
    wait_busy(1'b0, 20000);
    cnt0 = pulse_count;
    repeat (2000) @(posedge clk_sys);
    check({saw_done, abnormal_end_flag}, 2'b00);
    check(pulse_count, cnt0);
    // normal homing with the dog a random distance away
    cam_len <= 16'h4;
    start_run(32'h1, 1'b1, 16'h3 + 16'($urandom_range(3)));
    check(near_point_reserved, 1'b0);
    wait_busy(1'b0, 40000);
    check({exec_complete_flag, abnormal_end_flag}, 2'b10);
    check(late_count, 16'h0);
    check(pulse_count, 32'(rise_at + cam_len));
    apb(1'b0, `ZRS_POSITION_ADDR, 32'h0, 33'h0);
    apb(1'b0, `ZRS_STATUS_ADDR, 32'h0, 33'h2);
    apb(1'b1, `ZRS_CTRL_ADDR, 32'h0, 33'h0);
    // clear output routing: four default channels, then a chosen device
    for (int i = 0; i < 5; i++)
    begin
      do_reset();
      apb(1'b1, `ZRS_MAX_SPEED_ADDR, 32'h0007A120, 33'h0);
      apb(1'b1, `ZRS_ZR_SPEED_ADDR, 32'h0007A120, 33'h0);
      apb(1'b1, `ZRS_CREEP_SPEED_ADDR, 32'h0007A120, 33'h0);
      ch = (i < 4) ? 2'(i) : 2'($urandom_range(3));
      exp_clr = (i < 4) ? (8'h10 << i) : (8'h01 << $urandom_range(7));
      if (i == 4)
        apb(1'b1, `ZRS_CLR_DEV_ADDR, {29'h0, 3'($clog2(exp_clr))}, 33'h0);
      cam_len <= 16'h2;
      start_run({26'h0, ch, (i == 4) ? 4'hF : 4'hB}, 1'b1, 16'h2);
      k = 0;
      while (clear_out === 8'h00 && k < 4000)
      begin
        @(posedge clk_sys);
        k++;
      end
      check(clear_out, exp_clr);
      check(near_point_reserved, 1'b1);
    end
    do_reset();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
